// ==== design/lprs_pkg.sv ====
// Constants shared by the low-power entry and reset sequencer.
// Assumes a 100 MHz always-on system clock and a synchronous active-high reset.
package lprs_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int POR_STABLE_NS = 1000;
	localparam int POR_STABLE_CYC = (POR_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
	localparam int ROK_SETTLE_CYC = 3;
	// ----------------------------------------
	// Voltage codes and reset values
	// ----------------------------------------
	localparam logic [4:0] VCODE_1V8 = 5'h10;
	localparam logic [4:0] VCODE_1V35 = 5'h0B;
	localparam logic [15:0] STROBE_WIDTH_RST = 16'h0064;
	localparam logic RST_MODE_SWITCHING = 1'b0;
	localparam logic RST_CLK_SRC_FAST = 1'b1;
	localparam logic RST_SLOW_PD = 1'b0;
	localparam logic RST_FAST_PD = 1'b0;
	localparam logic [7:0] PASSCODE = 8'hA5;
	typedef enum logic [2:0] {
		LPRS_POR, LPRS_STROBE, LPRS_WAIT_ROK, LPRS_RUN
	} lprs_seq_t;
endpackage

// ==== design/lprs_top.sv ====
// Low-power entry and reset sequencer for the always-on domain.
// Assumes core_halt_in and wake_event_in come from logic on ref_clk_in; pins are synchronised.
`timescale 1ns/10ps

// Overview of operation
// - On halt, gate processor and memory clocks when their halt-gating enables are set.
// - On halt, power down oscillators per the firmware-written power-down bits.
// - Latch enables clear defer power-down to halt; set lets bits act directly.
// - With exit-to-fast set, wake switches system clock to the fast oscillator.
// - A new voltage code reaches the regulator only after a strobe.
// - Regulator control changes only with the correct passcode.
// - Power-on reset releases after the supply stays good for a fixed time.
// - External reset asserts all three resets; release frees power-on reset only.
// - Reset defaults: switching mode, slow oscillator on, fast oscillator selected.
// - During reset, strobe the regulator to switching 1.8 V for the strobe width.
// - After the strobe, wait for regulation-ok, then release cold and warm resets.
// - Wake latches the event and clears oscillator power-down, restoring settings.
module lprs_top (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Pins from outside
	input wire logic ext_reset_n_in,
	input wire logic supply_good_in,
	input wire logic regulation_ok_in,
	// Core and wake
	input wire logic core_halt_in,
	input wire logic wake_event_in,
	// Firmware control bits
	input wire logic cpu_halt_gate_en_in,
	input wire logic mem_halt_gate_en_in,
	input wire logic fast_osc_powerdown_in,
	input wire logic slow_osc_powerdown_in,
	input wire logic fast_osc_powerdown_latch_en_in,
	input wire logic slow_osc_powerdown_latch_en_in,
	input wire logic exit_to_fast_osc_in,
	input wire logic system_clock_source_select_in,
	input wire logic [15:0] strobe_width_count_in,
	// Regulator control write
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_passcode_in,
	input wire logic [4:0] reg_voltage_code_in,
	input wire logic reg_mode_select_in,
	input wire logic reg_strobe_in,
	input wire logic reg_ok_mask_in,
	// Reset outputs, active low
	output logic por_rst_n_out,
	output logic cold_rst_n_out,
	output logic warm_rst_n_out,
	// Clock and oscillator control
	output logic cpu_clk_gate_out,
	output logic mem_clk_gate_out,
	output logic fast_osc_pd_out,
	output logic slow_osc_pd_out,
	output logic clk_src_fast_out,
	output logic wake_latched_out,
	// Regulator
	output logic [4:0] regulator_voltage_code_out,
	output logic regulator_mode_select_out,
	output logic regulation_ok_mask_out,
	output logic voltage_apply_strobe_out
);
	import lprs_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] rstn_s_q, sup_s_q, rok_s_q;
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			rstn_s_q <= 2'b00;
			sup_s_q <= 2'b00;
			rok_s_q <= 2'b00;
		end else begin
			rstn_s_q <= {rstn_s_q[0], ext_reset_n_in};
			sup_s_q <= {sup_s_q[0], supply_good_in};
			rok_s_q <= {rok_s_q[0], regulation_ok_in};
		end
	end
	wire ext_rstn = rstn_s_q[1];
	wire sup_ok = sup_s_q[1];
	wire rok = rok_s_q[1];

	// ----------------------------------------
	// Reset sequencer
	// ----------------------------------------
	lprs_seq_t st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	wire rst_all = !ext_rstn;
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		if (rst_all || (st_q == LPRS_POR && !sup_ok)) begin
			st_d = LPRS_POR;
			cnt_d = '0;
		end else begin
			case (st_q)
				LPRS_POR: begin
					if (cnt_q == CNT_W'(POR_STABLE_CYC - 1)) begin
						st_d = LPRS_STROBE;
						cnt_d = '0;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				LPRS_STROBE: begin
					if (cnt_q + 1'b1 >= strobe_width_count_in) begin
						st_d = LPRS_WAIT_ROK;
						cnt_d = '0;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				LPRS_WAIT_ROK: begin
					if (rok && cnt_q == CNT_W'(ROK_SETTLE_CYC)) begin
						st_d = LPRS_RUN;
					end else if (cnt_q != CNT_W'(ROK_SETTLE_CYC)) begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				LPRS_RUN: st_d = LPRS_RUN;
				default: st_d = LPRS_POR;
			endcase
		end
	end
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			st_q <= LPRS_POR;
			cnt_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
		end
	end
	assign por_rst_n_out = (st_q != LPRS_POR);
	assign cold_rst_n_out = (st_q == LPRS_RUN);
	assign warm_rst_n_out = (st_q == LPRS_RUN);
	assign voltage_apply_strobe_out = (st_q == LPRS_STROBE);

	// ----------------------------------------
	// Regulator control register
	// ----------------------------------------
	logic [4:0] vcode_q, vcode_d, vapplied_q, vapplied_d;
	logic mode_q, mode_d, mask_q, mask_d, fw_strb_q, fw_strb_d;
	always_comb begin
		vcode_d = vcode_q;
		vapplied_d = vapplied_q;
		mode_d = mode_q;
		mask_d = mask_q;
		fw_strb_d = fw_strb_q;
		if (st_q != LPRS_RUN) begin
			vcode_d = VCODE_1V8;
			vapplied_d = VCODE_1V8;
			mode_d = RST_MODE_SWITCHING;
			mask_d = 1'b0;
			fw_strb_d = 1'b0;
		end else begin
			if (reg_wr_in && reg_passcode_in == PASSCODE) begin
				vcode_d = reg_voltage_code_in;
				mode_d = reg_mode_select_in;
				mask_d = reg_ok_mask_in;
				fw_strb_d = reg_strobe_in;
			end
			if (fw_strb_d && !fw_strb_q) begin
				vapplied_d = vcode_d;
			end
		end
	end
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			vcode_q <= VCODE_1V8;
			vapplied_q <= VCODE_1V8;
			mode_q <= RST_MODE_SWITCHING;
			mask_q <= 1'b0;
			fw_strb_q <= 1'b0;
		end else begin
			vcode_q <= vcode_d;
			vapplied_q <= vapplied_d;
			mode_q <= mode_d;
			mask_q <= mask_d;
			fw_strb_q <= fw_strb_d;
		end
	end
	assign regulator_voltage_code_out = vapplied_q;
	assign regulator_mode_select_out = mode_q;
	assign regulation_ok_mask_out = mask_q;

	// ----------------------------------------
	// Halt, power-down and wake
	// ----------------------------------------
	logic halted_q, halted_d, wake_q, wake_d, src_q, src_d, ovr_q, ovr_d;
	logic fpd_q, fpd_d, spd_q, spd_d, cg_q, cg_d, mg_q, mg_d;
	always_comb begin
		halted_d = halted_q;
		wake_d = 1'b0;
		src_d = system_clock_source_select_in;
		ovr_d = ovr_q && st_q == LPRS_RUN && !core_halt_in && !system_clock_source_select_in;
		if (st_q != LPRS_RUN) begin
			halted_d = 1'b0;
			src_d = RST_CLK_SRC_FAST;
		end else if (halted_q && wake_event_in) begin
			// The wake wins over a halt seen in the same cycle.
			halted_d = 1'b0;
			wake_d = 1'b1;
			if (exit_to_fast_osc_in) begin
				ovr_d = 1'b1;
			end
		end else if (core_halt_in) begin
			halted_d = 1'b1;
		end
		if (ovr_d) begin
			src_d = 1'b1;
		end
		cg_d = halted_d && cpu_halt_gate_en_in;
		mg_d = halted_d && mem_halt_gate_en_in;
		fpd_d = fast_osc_powerdown_in && (halted_d || fast_osc_powerdown_latch_en_in);
		spd_d = slow_osc_powerdown_in && (halted_d || slow_osc_powerdown_latch_en_in);
		if (wake_d || st_q != LPRS_RUN) begin
			fpd_d = RST_FAST_PD;
			spd_d = RST_SLOW_PD;
		end
	end
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			halted_q <= 1'b0;
			wake_q <= 1'b0;
			src_q <= RST_CLK_SRC_FAST;
			ovr_q <= 1'b0;
			fpd_q <= RST_FAST_PD;
			spd_q <= RST_SLOW_PD;
			cg_q <= 1'b0;
			mg_q <= 1'b0;
		end else begin
			halted_q <= halted_d;
			wake_q <= wake_d;
			src_q <= src_d;
			ovr_q <= ovr_d;
			fpd_q <= fpd_d;
			spd_q <= spd_d;
			cg_q <= cg_d;
			mg_q <= mg_d;
		end
	end
	assign cpu_clk_gate_out = cg_q;
	assign mem_clk_gate_out = mg_q;
	assign fast_osc_pd_out = fpd_q;
	assign slow_osc_pd_out = spd_q;
	assign clk_src_fast_out = src_q;
	assign wake_latched_out = wake_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_strobe_then_wait;
		voltage_apply_strobe_out ##1 !voltage_apply_strobe_out && st_q == LPRS_WAIT_ROK;
	endsequence
	a_reset_all_low: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$fell(rstn_s_q[1]) |=> !por_rst_n_out && !cold_rst_n_out && !warm_rst_n_out)
		else $error("external reset did not assert all resets");
	a_cold_after_rok: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$rose(cold_rst_n_out) |-> $past(rok) && warm_rst_n_out)
		else $error("cold reset released without regulation ok");
	a_strobe_seq: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$fell(voltage_apply_strobe_out) && ext_rstn |-> $past(st_q) == LPRS_STROBE)
		else $error("strobe ended outside strobe state");
	a_strobe_leads: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$rose(cold_rst_n_out) |-> !$past(voltage_apply_strobe_out))
		else $error("cold reset released during strobe");
	a_por_stable: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$rose(por_rst_n_out) |-> $past(sup_ok, 2))
		else $error("power-on reset released without good supply");
	a_halt_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		cpu_clk_gate_out |-> cpu_halt_gate_en_in || $past(cpu_halt_gate_en_in))
		else $error("cpu clock gated without enable");
	a_pd_deferred: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$rose(fast_osc_pd_out) |-> $past(fast_osc_powerdown_latch_en_in) || halted_q)
		else $error("fast oscillator powered down before halt");
	a_wake_restore: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		wake_latched_out |-> !fast_osc_pd_out && !slow_osc_pd_out)
		else $error("oscillators still down after wake");
	a_wake_fast: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		wake_latched_out && $past(exit_to_fast_osc_in) |-> clk_src_fast_out)
		else $error("wake did not select fast oscillator");
	a_vcode_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		cold_rst_n_out && $past(cold_rst_n_out) && !$rose(fw_strb_q) |-> $stable(vapplied_q))
		else $error("voltage code changed without strobe");
	a_strobe_wait: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		s_strobe_then_wait |=> !cold_rst_n_out || rok)
		else $error("reset release ordering wrong");
endmodule

// ==== tb/lprs_reg_model.sv ====
// Behavioural model of the on-die regulator that faces the sequencer.
// Assumes the strobe comes from logic on the same clock as this model.
`timescale 1ns/10ps

module lprs_reg_model #(
	parameter int OK_DELAY = 20,
	parameter bit BYPASS = 1'b0
) (
	// ----------------------------------------
	// Clock and strobe
	// ----------------------------------------
	input wire logic ref_clk_in,
	input wire logic voltage_apply_strobe_in,
	// ----------------------------------------
	// Regulation status
	// ----------------------------------------
	output logic regulation_ok_out
);
	logic strobe_q;
	int wait_q;

	// A regulator that has just been power cycled comes up in regulation.
	initial begin
		regulation_ok_out = 1'b1;
		strobe_q = 1'b0;
		wait_q = 0;
	end

	always @(posedge ref_clk_in) begin
		strobe_q <= voltage_apply_strobe_in;
		if (voltage_apply_strobe_in && !strobe_q && !BYPASS) begin
			regulation_ok_out <= 1'b0;
			wait_q <= OK_DELAY;
		end else if (!voltage_apply_strobe_in && wait_q != 0) begin
			wait_q <= wait_q - 1;
			if (wait_q == 1) begin
				regulation_ok_out <= 1'b1;
			end
		end
	end
endmodule

// ==== tb/test_lprs_top.sv ====
// Self-checking bench for the low-power entry and reset sequencer.
// Assumes the regulator model above and the passcode from the package.
`timescale 1ns/10ps

module test_lprs_top;
	import lprs_pkg::*;
	logic clk = 1'b0, rst = 1'b1, ext_n = 1'b0, rok;
	logic halt = 1'b0, wake = 1'b0, cpu_en = 1'b0, mem_en = 1'b0, fpd = 1'b0, spd = 1'b0;
	logic flat = 1'b0, slat = 1'b0, exitf = 1'b0, sel = 1'b1, sup = 1'b1;
	logic [15:0] swc = 16'h0008;
	logic wr = 1'b0, mode = 1'b0, stb = 1'b0, mask = 1'b0;
	logic [7:0] pass = 8'h00;
	logic [4:0] code = 5'h10;
	logic por_n, cold_n, warm_n, cg, mg, fpo, spo, srco, wk, modeo, masko, vstb, seen;
	logic [4:0] codeo;
	logic [4:0] rows [4] = '{5'b11110, 5'b10101, 5'b01011, 5'b00000};
	int fails = 0, check_count = 0, n;

	always #5 clk = ~clk;

	lprs_top i_lprs_top (.ref_clk_in(clk), .rst_in(rst), .ext_reset_n_in(ext_n),
		.supply_good_in(sup), .regulation_ok_in(rok), .core_halt_in(halt),
		.wake_event_in(wake), .cpu_halt_gate_en_in(cpu_en), .mem_halt_gate_en_in(mem_en),
		.fast_osc_powerdown_in(fpd), .slow_osc_powerdown_in(spd),
		.fast_osc_powerdown_latch_en_in(flat), .slow_osc_powerdown_latch_en_in(slat),
		.exit_to_fast_osc_in(exitf), .system_clock_source_select_in(sel),
		.strobe_width_count_in(swc), .reg_wr_in(wr), .reg_passcode_in(pass),
		.reg_voltage_code_in(code), .reg_mode_select_in(mode), .reg_strobe_in(stb),
		.reg_ok_mask_in(mask), .por_rst_n_out(por_n), .cold_rst_n_out(cold_n),
		.warm_rst_n_out(warm_n), .cpu_clk_gate_out(cg), .mem_clk_gate_out(mg),
		.fast_osc_pd_out(fpo), .slow_osc_pd_out(spo), .clk_src_fast_out(srco),
		.wake_latched_out(wk), .regulator_voltage_code_out(codeo),
		.regulator_mode_select_out(modeo), .regulation_ok_mask_out(masko),
		.voltage_apply_strobe_out(vstb));

	lprs_reg_model i_lprs_reg_model (.ref_clk_in(clk), .voltage_apply_strobe_in(vstb),
		.regulation_ok_out(rok));

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rwr(input logic [7:0] p, input logic [4:0] c, input logic m, s, k);
		pass = p;
		code = c;
		mode = m;
		stb = s;
		mask = k;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		cyc(2);
	endtask

	// Runs the release half of the external reset sequence and checks each step.
	task automatic reset_seq;
		n = 0;
		while (por_n !== 1'b1 && n < 400) begin cyc(1); n++; end
		chk("por_released", 8'h01, {7'h0, por_n});
		chk("cold_held", 8'h00, {7'h0, cold_n});
		n = 0;
		while (vstb !== 1'b1 && n < 40) begin cyc(1); n++; end
		n = 0;
		while (vstb === 1'b1 && n < 60) begin cyc(1); n++; end
		chk("strobe_width", swc[7:0], 8'(n));
		chk("code_reset", 8'(VCODE_1V8), {3'h0, codeo});
		chk("mode_reset", 8'h00, {7'h0, modeo});
		cyc(3);
		chk("cold_waits_ok", {7'h0, rok}, {7'h0, cold_n});
		n = 0;
		while (cold_n !== 1'b1 && n < 100) begin cyc(1); n++; end
		chk("cold_released", 8'h01, {7'h0, cold_n});
		chk("warm_released", 8'h01, {7'h0, warm_n});
		$display("reset sequence done");
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watchdog: the full run needs well under ten thousand cycles.
	initial begin
		#200000;
		fails++;
		close_out();
	end

	initial begin
		cyc(16);
		chk("defaults", 8'h04, {4'h0, por_n, srco, fpo, spo});
		rst = 1'b0;
		cyc(4);
		chk("ext_all_low", 8'h00, {5'h0, por_n, cold_n, warm_n});
		ext_n = 1'b1;
		reset_seq();
		// Firmware has selected the slow clock before any entry.
		sel = 1'b0;
		for (int i = 0; i < 4; i++) begin
			{cpu_en, mem_en, fpd, spd, exitf} = rows[i];
			cyc(2);
			chk("pd_deferred", 8'h00, {6'h0, fpo, spo});
			halt = 1'b1;
			cyc(2);
			chk("halt_outputs", {4'h0, rows[i][4:1]}, {4'h0, cg, mg, fpo, spo});
			wake = 1'b1;
			halt = 1'b0;
			cyc(1);
			wake = 1'b0;
			seen = wk;
			repeat (3) begin cyc(1); seen = seen | wk; end
			chk("wake_pulse", 8'h01, {7'h0, seen});
			chk("wake_pd_clear", 8'h00, {6'h0, fpo, spo});
			chk("wake_src", {7'h0, rows[i][0]}, {7'h0, srco});
			{fpd, spd} = 2'b00;
			$display("halt row %0d done", i);
		end
		{flat, slat, fpd, spd} = 4'hF;
		cyc(2);
		chk("direct_pd", 8'h03, {6'h0, fpo, spo});
		{fpd, spd} = 2'b00;
		rwr(PASSCODE, VCODE_1V35, 1'b0, 1'b0, 1'b1);
		chk("code_no_strobe", 8'(VCODE_1V8), {3'h0, codeo});
		chk("mask_set", 8'h01, {7'h0, masko});
		rwr(PASSCODE, VCODE_1V35, 1'b0, 1'b1, 1'b1);
		chk("code_strobed", 8'(VCODE_1V35), {3'h0, codeo});
		cyc(100);
		rwr(PASSCODE, VCODE_1V35, 1'b0, 1'b0, 1'b1);
		cyc(200);
		chk("code_after_clear", 8'(VCODE_1V35), {3'h0, codeo});
		rwr(PASSCODE, VCODE_1V35, 1'b1, 1'b0, 1'b1);
		chk("mode_linear", 8'h03, {6'h0, modeo, masko});
		rwr(~PASSCODE, VCODE_1V8, 1'b0, 1'b0, 1'b0);
		chk("bad_pass", 8'h03, {6'h0, modeo, masko});
		$display("regulator writes done");
		ext_n = 1'b0;
		swc = 16'h0001;
		cyc(4);
		chk("ext_again_low", 8'h00, {5'h0, por_n, cold_n, warm_n});
		ext_n = 1'b1;
		cyc(50);
		sup = 1'b0;
		cyc(5);
		sup = 1'b1;
		cyc(60);
		chk("por_waits_supply", 8'h00, {7'h0, por_n});
		reset_seq();
		close_out();
	end
endmodule
